// file: hdl/sac_map.svh
// Purpose: Named offsets, field positions and timing figures of the converter link.
// Assumes: Included by bare name from the package and both ends.
// Notes: Definitions only.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_WORD_BITS 16
`define SAC_CODE_BITS 13
`define SAC_SAR_STEPS 8192
`define SAC_FIRST_SAR_EDGE 2
`define SAC_TRACK_EDGE 14
`define SAC_WR_BIT 15
`define SAC_SEL_BIT 14
`define SAC_CHAN_LSB 10
`define SAC_MODE_LSB 8
`define SAC_PM_LSB 6
`define SAC_CODING_BIT 5
`define SAC_REF_BIT 4
`define SAC_SEQ_BIT 3
`define SAC_RANGE_LSB 0
`define SAC_RST_RANGES 8'h00
`define SAC_CLK_NS 4
`define SAC_SCLK_HALF_NS 24
`define SAC_MIN_HALF_CYC 6
`define SAC_SPAN_10_UV 20000000
`define SAC_SPAN_5_UV 10000000
`define SAC_SPAN_2P5_UV 5000000
`define SAC_SPAN_UNI_UV 10000000
`endif

// file: hdl/sac_pkg.sv
// Purpose: Types shared by both ends of the converter link.
// Assumes: sac_map.svh supplies the numbers.
// Notes: State of each end is one packed struct.
`default_nettype none
`include "sac_map.svh"
package sac_pkg;
  typedef enum logic [1:0] {RNG_BI10, RNG_BI5, RNG_BI2P5, RNG_UNI10} sac_range_t;
  typedef enum logic [1:0] {CFG_SINGLE, CFG_PSEUDO3, CFG_TRUE_DIFF, CFG_PSEUDO2} sac_cfg_t;
  typedef enum logic [1:0] {PM_NORMAL, PM_FULL_DOWN, PM_AUTO_DOWN, PM_AUTO_STBY} sac_pm_t;
  typedef enum {H_IDLE, H_FRAME, H_TAIL, H_GAP} sac_hst_t;

  typedef struct packed {
    logic cs_s1, cs_s2, cs_s3;
    logic ck_s1, ck_s2, ck_s3;
    logic di_s1, di_s2;
    logic [4:0] rise_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic dout;
    logic dout_oe;
    logic [1:0] chan;
    sac_cfg_t cfg;
    sac_pm_t pm;
    logic coding;
    logic ref_int;
    logic seq;
    logic [7:0] ranges;
    logic [1:0] cur_ch;
    logic [1:0] conv_ch;
    logic signed [31:0] vin;
    logic signed [31:0] vmin;
    logic [31:0] fs;
    logic [12:0] sar;
    logic [12:0] result;
    logic [1:0] res_ch;
    logic res_stb;
    logic track;
    logic pwr_dn;
  } sac_dev_st_t;

  typedef struct packed {
    logic [1:0] st;
    logic [7:0] cnt;
    logic sclk;
    logic cs_n;
    logic din;
    logic [4:0] bits;
    logic [15:0] tx;
    logic [15:0] rx;
    logic ds1, ds2;
    logic busy;
    logic rxv;
    logic [15:0] rxw;
  } sac_host_st_t;
endpackage : sac_pkg
`default_nettype wire

// file: hdl/sac_link_if.sv
// Purpose: Serial pins between the host controller and the converter.
// Assumes: The converter drives its data pin only while selected.
// Notes: The shared data wire is resolved here from the enable.
`default_nettype none
interface sac_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout_w;
  // A released pin reads as the inverse of the last bit, so a late sample shows up.
  assign dout_w = dout_oe ? dout_o : ~dout_o;
  modport dev (input cs_n, input sclk, input din, output dout_o, output dout_oe);
  modport host (output cs_n, output sclk, output din, input dout_w);
endinterface : sac_link_if
`default_nettype wire

// file: hdl/sac_host.sv
// Purpose: Host end: frames one 16-bit word out and one in per request.
// Assumes: clk_sys at 250 MHz; the serial clock is made here by a divider.
// Notes: Serial clock idles low; data changes on falling edges, is taken on rising ones.
`default_nettype none
`include "sac_map.svh"
module sac_host #(
  parameter int HALF_CYC = `SAC_SCLK_HALF_NS / `SAC_CLK_NS
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Link pins.
  sac_link_if.host link,
  // User request.
  input wire logic start,
  input wire logic [15:0] tx_word,
  // User answer.
  output logic busy,
  output logic rx_valid,
  output logic [15:0] rx_word
);
  sac_pkg::sac_host_st_t q, d;

  // The device answers three cycles after it sees an edge; with two sync stages here a
  // shorter half period would sample the data pin before it has moved.
  if (HALF_CYC < `SAC_MIN_HALF_CYC || HALF_CYC > 255) begin : g_half_check
    $error("sac_host: HALF_CYC out of range");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  always_comb begin
    d = q;
    d.ds1 = link.dout_w;
    d.ds2 = q.ds1;
    d.rxv = 1'b0;
    case (sac_pkg::sac_hst_t'(q.st))
      sac_pkg::H_IDLE: begin
        if (start) begin
          d.tx = tx_word;
          d.din = tx_word[`SAC_WR_BIT];
          d.cs_n = 1'b0;
          d.busy = 1'b1;
          d.cnt = 8'h00;
          d.bits = 5'h00;
          d.st = 2'(sac_pkg::H_FRAME);
        end
      end
      sac_pkg::H_FRAME: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == HALF_LAST) begin
          d.cnt = 8'h00;
          if (!q.sclk) begin
            d.sclk = 1'b1;
            d.rx = {q.rx[14:0], q.ds2};
          end else begin
            d.sclk = 1'b0;
            d.bits = q.bits + 5'h01;
            if (q.bits == 5'(`SAC_WORD_BITS - 1)) begin
              d.st = 2'(sac_pkg::H_TAIL);
            end else begin
              d.tx = {q.tx[14:0], 1'b0};
              d.din = q.tx[14];
            end
          end
        end
      end
      sac_pkg::H_TAIL: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == HALF_LAST) begin
          d.cnt = 8'h00;
          d.cs_n = 1'b1;
          d.rxv = 1'b1;
          d.rxw = q.rx;
          d.st = 2'(sac_pkg::H_GAP);
        end
      end
      sac_pkg::H_GAP: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == HALF_LAST) begin
          d.cnt = 8'h00;
          d.busy = 1'b0;
          d.st = 2'(sac_pkg::H_IDLE);
        end
      end
      default: begin
        d.st = 2'(sac_pkg::H_IDLE);
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '{st: 2'(sac_pkg::H_IDLE), cs_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.din = q.din;
  assign busy = q.busy;
  assign rx_valid = q.rxv;
  assign rx_word = q.rxw;
endmodule : sac_host
`default_nettype wire

// file: hdl/sac_dev.sv
// Purpose: Converter end: control and range registers, SAR search, output coding.
// Assumes: Link pins are asynchronous to clk_sys; analog inputs are quasi-static words.
// Notes: Each frame returns the result of the previous conversion.
`default_nettype none
`include "sac_map.svh"
//
// Contract
// - Each channel gets one of four ranges.
// - Two mode bits pick input arrangement.
// - Power-up: four single-ended inputs until written.
// - Serial clock shifts data and clocks conversion.
// - Power-up selects external reference; bit switches internal.
// - Programmed power-down mode applies between conversions.
// - Twos complement default; coding bit gives binary.
// - Sequence uses coding from last control write.
// - 13-bit code, 8192 steps across range.
// - Code transitions at whole LSB multiples.
// - SAR search by control logic forms code.
// - Track on 14th rising edge, hold at select.
// - Differential twos complement spans -4096 to +4095.
module sac_dev (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Link pins.
  sac_link_if.dev link,
  // Analog front end model, microvolts per input pin.
  input wire logic signed [31:0] ain_uv [4],
  // Configuration seen by the analog side.
  output logic track,
  output logic pwr_dn,
  output logic ref_int,
  output logic [1:0] in_cfg,
  output logic [7:0] ranges,
  // Completed conversions.
  output logic res_stb,
  output logic [1:0] res_ch,
  output logic [12:0] result
);
  sac_pkg::sac_dev_st_t q, d;

  function automatic logic [31:0] span_uv(input logic [1:0] r);
    case (sac_pkg::sac_range_t'(r))
      sac_pkg::RNG_BI10: span_uv = 32'(`SAC_SPAN_10_UV);
      sac_pkg::RNG_BI5: span_uv = 32'(`SAC_SPAN_5_UV);
      sac_pkg::RNG_BI2P5: span_uv = 32'(`SAC_SPAN_2P5_UV);
      default: span_uv = 32'(`SAC_SPAN_UNI_UV);
    endcase
  endfunction

  // Keep a trial bit when the input sits at or above the trial level.
  function automatic logic sar_keep(input logic signed [31:0] vin,
                                    input logic signed [31:0] vmin,
                                    input logic [31:0] fs, input logic [12:0] trial);
    longint lhs;
    longint rhs;
    lhs = longint'(vin) * longint'(`SAC_SAR_STEPS);
    rhs = longint'(vmin) * longint'(`SAC_SAR_STEPS) + longint'(trial) * longint'(fs);
    sar_keep = (lhs >= rhs);
  endfunction

  logic cs_fall, cs_rise, ck_rise, ck_fall;
  logic [1:0] pick_ch;
  logic [1:0] rsel;
  logic [1:0] pos_i, neg_i;
  logic use_neg;
  logic [3:0] bit_idx;
  logic [12:0] trial;
  logic [12:0] coded;
  logic keep;
  logic [12:0] sar_next;

  always_comb begin
    cs_fall = q.cs_s3 & ~q.cs_s2;
    cs_rise = ~q.cs_s3 & q.cs_s2;
    ck_rise = ~q.ck_s3 & q.ck_s2;
    ck_fall = q.ck_s3 & ~q.ck_s2;
    pick_ch = q.seq ? q.cur_ch : q.chan;
    // Map the logical channel onto positive and negative pins for the arrangement.
    pos_i = pick_ch;
    neg_i = 2'h3;
    use_neg = 1'b0;
    case (q.cfg)
      sac_pkg::CFG_SINGLE: begin
        use_neg = 1'b0;
      end
      sac_pkg::CFG_PSEUDO3: begin
        use_neg = 1'b1;
        neg_i = 2'h3;
      end
      sac_pkg::CFG_TRUE_DIFF, sac_pkg::CFG_PSEUDO2: begin
        use_neg = 1'b1;
        pos_i = {pick_ch[0], 1'b0};
        neg_i = {pick_ch[0], 1'b1};
      end
      default: begin
        use_neg = 1'b0;
      end
    endcase
    rsel = q.ranges[2 * pos_i +: 2];
    // Bit 12 is tried on the second rise and bit 0 on the fourteenth.
    bit_idx = 4'(`SAC_TRACK_EDGE - 1) - 4'(q.rise_cnt);
    trial = q.sar | (13'h0001 << bit_idx);
    keep = sar_keep(q.vin, q.vmin, q.fs, trial);
    sar_next = keep ? trial : q.sar;
    // Code the searched value so the bit decided on the last rise is part of the result.
    coded = q.coding ? sar_next : {~sar_next[12], sar_next[11:0]};
  end

  always_comb begin
    d = q;
    d.cs_s1 = link.cs_n;
    d.cs_s2 = q.cs_s1;
    d.cs_s3 = q.cs_s2;
    d.ck_s1 = link.sclk;
    d.ck_s2 = q.ck_s1;
    d.ck_s3 = q.ck_s2;
    d.di_s1 = link.din;
    d.di_s2 = q.di_s1;
    d.res_stb = 1'b0;

    if (cs_fall) begin
      // Hold the selected input and start a new search.
      d.track = 1'b0;
      d.rise_cnt = 5'h00;
      d.sar = 13'h0000;
      d.conv_ch = pick_ch;
      d.vin = use_neg ? (ain_uv[pos_i] - ain_uv[neg_i]) : ain_uv[pos_i];
      if (q.cfg == sac_pkg::CFG_TRUE_DIFF) begin
        d.fs = span_uv(rsel) << 1;
        d.vmin = -$signed(span_uv(rsel));
      end else if (use_neg) begin
        d.fs = span_uv(rsel);
        d.vmin = 32'sh0;
      end else begin
        d.fs = span_uv(rsel);
        d.vmin = (rsel == 2'(sac_pkg::RNG_UNI10)) ? 32'sh0 : -$signed(span_uv(rsel) >> 1);
      end
      d.tx = {1'b0, q.res_ch, q.result};
      d.dout = 1'b0;
      d.dout_oe = 1'b1;
    end else if (ck_rise && !q.cs_s2) begin
      d.rx = {q.rx[14:0], q.di_s2};
      if (q.rise_cnt != 5'h1F) begin
        d.rise_cnt = q.rise_cnt + 5'h01;
      end
      // Search one bit per rising edge, sign bit first.
      if (q.rise_cnt >= 5'(`SAC_FIRST_SAR_EDGE - 1) &&
          q.rise_cnt < 5'(`SAC_TRACK_EDGE)) begin
        if (keep) begin
          d.sar = trial;
        end
      end
      if (q.rise_cnt == 5'(`SAC_TRACK_EDGE - 1)) begin
        d.track = 1'b1;
        d.res_stb = 1'b1;
        d.result = coded;
        d.res_ch = q.conv_ch;
        if (q.seq) begin
          d.cur_ch = (q.cur_ch == q.chan) ? 2'h0 : q.cur_ch + 2'h1;
        end
      end
    end else if (ck_fall && !q.cs_s2) begin
      d.tx = {q.tx[14:0], 1'b0};
      d.dout = q.tx[14];
    end else if (cs_rise) begin
      d.dout_oe = 1'b0;
      // Only a complete frame with the write flag updates a register.
      if (q.rise_cnt == 5'(`SAC_WORD_BITS) && q.rx[`SAC_WR_BIT]) begin
        if (q.rx[`SAC_SEL_BIT]) begin
          d.ranges = q.rx[`SAC_RANGE_LSB +: 8];
        end else begin
          d.chan = q.rx[`SAC_CHAN_LSB +: 2];
          d.cfg = sac_pkg::sac_cfg_t'(q.rx[`SAC_MODE_LSB +: 2]);
          d.pm = sac_pkg::sac_pm_t'(q.rx[`SAC_PM_LSB +: 2]);
          d.coding = q.rx[`SAC_CODING_BIT];
          d.ref_int = q.rx[`SAC_REF_BIT];
          d.seq = q.rx[`SAC_SEQ_BIT];
          d.cur_ch = 2'h0;
        end
      end
    end

    // Auto modes power down only while deselected; full shutdown holds until rewritten.
    case (d.pm)
      sac_pkg::PM_FULL_DOWN: d.pwr_dn = 1'b1;
      sac_pkg::PM_AUTO_DOWN, sac_pkg::PM_AUTO_STBY: d.pwr_dn = q.cs_s2 & d.track;
      default: d.pwr_dn = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
             cfg: sac_pkg::CFG_SINGLE,
             pm: sac_pkg::PM_NORMAL,
             coding: 1'b0,
             ref_int: 1'b0,
             ranges: `SAC_RST_RANGES,
             track: 1'b1,
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.dout_o = q.dout;
  assign link.dout_oe = q.dout_oe;
  assign track = q.track;
  assign pwr_dn = q.pwr_dn;
  assign ref_int = q.ref_int;
  assign in_cfg = q.cfg;
  assign ranges = q.ranges;
  assign res_stb = q.res_stb;
  assign res_ch = q.res_ch;
  assign result = q.result;
endmodule : sac_dev
`default_nettype wire

// file: verif/sac_link_monitor.sv
// Purpose: Wire checks on the serial link between host and converter.
// Assumes: Link signals are sampled in the clk_sys domain.
// Notes: Counts follow a host divider of 6 cycles per half period.
`default_nettype none
module sac_link_monitor (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Link pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [4:0] rise_q;
  // The count clears while deselected, so a frame's total is still visible at the deselect edge.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      rise_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      rise_q <= cs_n ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("Serial clock high while deselected.");
  clock_high_a: assert property ($rose(sclk) |-> sclk[*6])
    else $error("Serial clock high phase too short.");
  din_steady_a: assert property (sclk |-> $stable(din))
    else $error("Host data moved while clock high.");
  dout_steady_a: assert property (dout_oe && sclk |-> $stable(dout_o))
    else $error("Converter data moved while clock high.");
  drive_on_a: assert property ($fell(cs_n) |-> ##[1:6] dout_oe)
    else $error("Converter did not drive after select.");
  drive_off_a: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
    else $error("Converter kept driving after deselect.");
  frame_length_a: assert property ($rose(cs_n) |-> rise_q == 5'h10)
    else $error("Frame did not carry sixteen clock rises.");
  lead_bit_a: assert property ($rose(sclk) && rise_q == 5'h00 |-> dout_oe && !dout_o)
    else $error("Leading converter bit not zero.");
endmodule // sac_link_monitor
`default_nettype wire

// file: verif/sar_adc_config_and_coding_tb.sv
// Purpose: Frames words between host and converter, checks codes and settings.
// Assumes: Analog pins are static words in microvolts.
// Notes: A small model tracks the settings that each frame converts with.
`default_nettype none
`include "sac_map.svh"
module sar_adc_config_and_coding_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic busy, rx_valid, track, pwr_dn, ref_int, res_stb;
  logic [15:0] rx_word;
  logic [1:0] in_cfg, res_ch;
  logic [7:0] ranges;
  logic [12:0] result;
  logic signed [31:0] ain_uv [4];
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] m_rng = 8'h00;
  logic [15:0] m_ctl = 16'h0000;
  logic [14:0] prev = 15'h0000;
  logic have_prev = 1'b0;
  logic [1:0] m_cur = 2'h0;
  int n_stb = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (res_stb === 1'b1) n_stb <= n_stb + 1;
  end
  sac_link_if link();
  sac_host u_sac_host (.clk_sys(clk_sys), .rstn(rstn), .link(link), .start(start),
    .tx_word(tx_word), .busy(busy), .rx_valid(rx_valid), .rx_word(rx_word));
  sac_dev u_sac_dev (.clk_sys(clk_sys), .rstn(rstn), .link(link), .ain_uv(ain_uv),
    .track(track), .pwr_dn(pwr_dn), .ref_int(ref_int), .in_cfg(in_cfg), .ranges(ranges),
    .res_stb(res_stb), .res_ch(res_ch), .result(result));
  sac_link_monitor u_sac_link_monitor (.clk_sys(clk_sys), .rstn(rstn), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout_o(link.dout_o), .dout_oe(link.dout_oe));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Channel and code of a conversion made with the settings held before the frame.
  function automatic logic [14:0] expect_conv();
    logic [1:0] c, r, d;
    longint span, vin, vmin, fs, code;
    c = m_ctl[3] ? m_cur : m_ctl[11:10];
    d = m_ctl[9:8];
    r = m_rng[2*c +: 2];
    span = (r == 2'h0) ? `SAC_SPAN_10_UV : (r == 2'h1) ? `SAC_SPAN_5_UV :
           (r == 2'h2) ? `SAC_SPAN_2P5_UV : `SAC_SPAN_UNI_UV;
    vin = ain_uv[c];
    vmin = (r == 2'h3) ? 64'sh0 : -span / 64'sh2;
    fs = span;
    if (d != 2'h0) vin = (d == 2'h1) ? ain_uv[c] - ain_uv[3] : ain_uv[0] - ain_uv[1];
    if (d != 2'h0) vmin = (d == 2'h2) ? -span : 64'sh0;
    if (d == 2'h2) fs = 64'sh2 * span;
    code = (vin - vmin) * `SAC_SAR_STEPS / fs;
    if (code < 64'sh0) code = 64'sh0;
    if (code >= `SAC_SAR_STEPS) code = `SAC_SAR_STEPS - 1;
    return {c, code[12:0] ^ {!m_ctl[5], 12'h000}};
  endfunction

  // One frame; its answer carries the conversion of the frame before.
  task automatic frame(input logic [15:0] w);
    logic [14:0] cur;
    int k;
    int s0;
    cur = expect_conv();
    k = 0;
    s0 = n_stb;
    tx_word = w;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    repeat (20) @(negedge clk_sys);
    check("track held", {15'h0000, track}, 16'h0000);
    while (rx_valid !== 1'b1 && k < 1000) begin
      @(negedge clk_sys);
      k++;
    end
    check("rx_valid", {15'h0000, rx_valid}, 16'h0001);
    if (have_prev) check("rx_word", rx_word, {1'b0, prev});
    while (busy !== 1'b0 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    check("busy", {15'h0000, busy}, 16'h0000);
    check("result", {1'b0, res_ch, result}, {1'b0, cur});
    check("res_stb", 16'(n_stb - s0), 16'h0001);
    check("track idle", {15'h0000, track}, 16'h0001);
    // The sequence steps at the end of each conversion; a control write restarts it.
    if (m_ctl[3]) m_cur = (m_cur == m_ctl[11:10]) ? 2'h0 : m_cur + 2'h1;
    if (w[15] && w[14]) m_rng = w[7:0];
    if (w[15] && !w[14]) m_ctl = w;
    if (w[15] && !w[14]) m_cur = 2'h0;
    check("ranges", {8'h00, ranges}, {8'h00, m_rng});
    check("in_cfg", {14'h0000, in_cfg}, {14'h0000, m_ctl[9:8]});
    check("ref_int", {15'h0000, ref_int}, {15'h0000, m_ctl[4]});
    check("pwr_dn", {15'h0000, pwr_dn}, {15'h0000, m_ctl[7:6] != 2'h0});
    prev = cur;
    have_prev = 1'b1;
  endtask

  initial begin
    #100us;
    n_fail++;
    results();
  end

  initial begin
    ain_uv[0] = 32'sh002DC6C0;
    ain_uv[1] = -32'sh001312D0;
    ain_uv[2] = 32'sh000F4240;
    ain_uv[3] = 32'sh007270E0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    frame(16'h0000);
    frame(16'hC0E4);
    for (int c = 0; c < 4; c++) frame({4'h8, 2'(c), 10'h020});
    for (int d = 1; d < 4; d++) frame({6'h20, 2'(d), 2'(d), 6'h10});
    frame(16'h8428);
    ain_uv[0] = 32'sh00FFFFFF;
    frame(16'h0000);
    frame(16'h0000);
    frame(16'h0000);
    results();
  end
endmodule // sar_adc_config_and_coding_tb
`default_nettype wire
